// [hf_gain_defines.svh]
// Constants of the high-band gain decoder and smoother.
// Assumes Q8.8 dB values, 16-bit samples and Q16.16 linear gains.
`ifndef HF_GAIN_DEFINES_SVH
`define HF_GAIN_DEFINES_SVH
// ----------------------------------------
// Gain decoding
// ----------------------------------------
`define MEM_TARGET_DB 16'sh1400
`define MEM_DECAY 16'he666
`define STEP_DB 18'sh00300
`define HALF_OFFSET_DB 18'sh00480
`define FULL_OFFSET_DB 18'sh00a80
`define LOG2_10_OVER_20 16'h2a85
`define LIN_ONE 32'h00010000
`define LIN_MAX 32'hffffffff
// ----------------------------------------
// Pulse limiter and energy smoothing
// ----------------------------------------
`define THR_FEEDBACK 17'h0fae1
`define THR_INPUT 17'h0051f
`define ENERGY_FLOOR 40'h0000000001
`define SQRT2_UP 9'h16a
`define SQRT2_DOWN 9'h0b5
`define LAST_SAMPLE 6'h3f
`define LAST_STEP 6'h0f
`define SAMPLE_MAX 16'sh7fff
`define SAMPLE_MIN 16'sh8000
`endif

// [hf_gain_pkg.sv]
// Types shared by the high-band gain decoder and its bench.
// Assumes the constants header is compiled alongside.
package hf_gain_pkg;
	typedef enum logic [1:0] {
		quarter_length_frame,
		half_length_frame,
		full_length_frame
	} frame_len_e;
	typedef enum logic [1:0] {gain_idle, gain_fetch, gain_sub} gain_state_e;
	typedef enum logic [2:0] {
		smooth_fill,
		smooth_thres,
		smooth_div,
		smooth_sqrt,
		smooth_emit
	} smooth_state_e;
	typedef logic signed [15:0] db_t;
endpackage

// [stream_if.sv]
// Valid/ready stream carrier between the decoder and its buffers.
// Assumes source and sink share one clock.
`timescale 1ns/1ps
interface stream_if #(parameter int W = 16);
	logic [W-1:0] data;
	logic valid;
	logic ready;
	modport src(output data, output valid, input ready);
	modport snk(input data, input valid, output ready);
endinterface

// [hf_pair_buffer.sv]
// Two-entry valid/ready buffer for one output stream.
// Assumes a single clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module hf_pair_buffer #(
	parameter int W = 16
) (
	// Clock and reset
	input logic clk_in,
	input logic rst_in,
	// Streams
	stream_if.snk fill,
	stream_if.src drain
);
	logic [W-1:0] slot [2];
	logic wr_ptr;
	logic rd_ptr;
	logic [1:0] count;
	wire logic push = fill.valid && fill.ready;
	wire logic pop = drain.valid && drain.ready;

	// Two entries keep a stalled receiver from costing a word
	assign fill.ready = (count != 2'd2);
	assign drain.valid = (count != 2'd0);
	assign drain.data = slot[rd_ptr];

	// Pointer and occupancy bookkeeping
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'd0;
			slot[0] <= '0;
			slot[1] <= '0;
		end else begin
			if (push) begin
				slot[wr_ptr] <= fill.data;
				wr_ptr <= ~wr_ptr;
			end
			if (pop) begin
				rd_ptr <= ~rd_ptr;
			end
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule

// [hf_gain_decode_smoothing.sv]
// High-band gain decoder, excitation pulse limiter and energy smoother.
// Assumes frame parameters, samples and codebook data come from logic on clk_in.
// The codebook is an external ROM answering in the same cycle as cb_index_out.
//
// Overview of operation
// - Frame holds 4, 8 or 16 gain subframes for quarter, half, full length.
// - Subframe gain dB is interpolated estimate plus first and second stage.
// - One 7-bit first stage index selects a four-gain codebook vector.
// - Gain loss flag is element zero of the loss vector.
// - Without loss, gains are codebook vector plus the mean.
// - Under loss, memory moves toward -20 dB: 0.9 times (mem+20) minus 20.
// - Under loss gains are memory plus mean; memory reloads as average minus mean.
// - Each first stage gain spans 1, 2 or 4 subframes by frame length.
// - Quarter frames use zero second stage corrections.
// - Half frames: 2-bit index gives 3*idx-4.5 dB, zero under loss.
// - Full frames: 3-bit index gives 3*idx-10.5 dB, zero under loss.
// - Each subframe gain is converted to linear as ten to dB over 20.
// - Samples above twice the envelope are pulses, clipped to twice it, signed.
// - Envelope low-pass: input 0.02, feedback 0.98, zero after reset.
// - Half the excess is added to the envelope; excess pulls samples toward zero.
// - Subframe energy is 0.0001 plus the sum of 64 squared samples.
// - Smoothing threshold moves toward energy, limited by the 1.414 factor.
// - Subframe samples scale by square root of threshold over energy.
// - Estimate per subframe is i/nb new plus (1-i/nb) previous matching gain.
`timescale 1ns/1ps
`include "hf_gain_defines.svh"
module hf_gain_decode_smoothing #(
	parameter logic signed [15:0] MEAN_GAIN = 16'sh0000
) (
	// Clock and reset
	input logic clk_in,
	input logic rst_in,
	// Frame parameters
	input logic frame_valid_in,
	output logic frame_ready_out,
	input hf_gain_pkg::frame_len_e frame_len_in,
	input logic [3:0] loss_vec_in,
	input logic [6:0] stage1_index_in,
	input logic [47:0] stage2_index_in,
	input logic signed [15:0] match_gain_in,
	// Codebook ROM
	output logic [6:0] cb_index_out,
	input logic [63:0] cb_vector_in,
	// Linear gain stream
	output logic gain_valid_out,
	input logic gain_ready_in,
	output logic [31:0] gain_out,
	// Excitation stream
	input logic exc_valid_in,
	output logic exc_ready_out,
	input logic signed [15:0] exc_in,
	output logic exc_valid_out,
	input logic exc_ready_in,
	output logic [15:0] exc_out,
	// Synthesis stream
	input logic syn_valid_in,
	output logic syn_ready_out,
	input logic signed [15:0] syn_in,
	output logic syn_valid_out,
	input logic syn_ready_in,
	output logic [15:0] syn_out
);
	import hf_gain_pkg::*;

	// ----------------------------------------
	// dB to linear conversion
	// ----------------------------------------
	// Base-2 split with a linear mantissa; up to 6 % error traded for no table
	function automatic logic [31:0] db_to_lin(input logic signed [17:0] db);
		logic signed [33:0] prod;
		logic signed [17:0] l2;
		logic signed [9:0] ip;
		logic [31:0] mant;
		prod = db * $signed({1'b0, `LOG2_10_OVER_20});
		l2 = prod[33:16];
		ip = l2[17:8];
		mant = `LIN_ONE + {16'h0000, l2[7:0], 8'h00};
		if (ip > 10'sd14) begin
			db_to_lin = `LIN_MAX;
		end else if (ip < -10'sd17) begin
			db_to_lin = 32'h00000000;
		end else if (ip >= 10'sd0) begin
			db_to_lin = mant << ip[3:0];
		end else begin
			db_to_lin = mant >> 5'(-ip);
		end
	endfunction

	// ----------------------------------------
	// Output buffers
	// ----------------------------------------
	stream_if #(.W(32)) gain_s();
	stream_if #(.W(32)) gain_q();
	stream_if #(.W(16)) exc_s();
	stream_if #(.W(16)) exc_q();
	stream_if #(.W(16)) syn_s();
	stream_if #(.W(16)) syn_q();

	hf_pair_buffer #(.W(32)) gain_buf (.clk_in(clk_in), .rst_in(rst_in), .fill(gain_s), .drain(gain_q));
	hf_pair_buffer #(.W(16)) exc_buf (.clk_in(clk_in), .rst_in(rst_in), .fill(exc_s), .drain(exc_q));
	hf_pair_buffer #(.W(16)) syn_buf (.clk_in(clk_in), .rst_in(rst_in), .fill(syn_s), .drain(syn_q));

	// Buffered streams to the ports
	assign gain_valid_out = gain_q.valid;
	assign gain_out = gain_q.data;
	assign gain_q.ready = gain_ready_in;
	assign exc_valid_out = exc_q.valid;
	assign exc_out = exc_q.data;
	assign exc_q.ready = exc_ready_in;
	assign syn_valid_out = syn_q.valid;
	assign syn_out = syn_q.data;
	assign syn_q.ready = syn_ready_in;

	// ----------------------------------------
	// Gain decoding
	// ----------------------------------------
	gain_state_e gstate;
	frame_len_e flen;
	logic bfi;
	logic [47:0] idx2;
	db_t new_match;
	db_t old_match;
	db_t gain_mem;
	db_t g1 [4];
	db_t next_g1 [4];
	logic [3:0] sub;

	// Memory decay toward -20 dB under loss
	wire logic signed [16:0] mem_plus = 17'(gain_mem) + 17'(`MEM_TARGET_DB);
	wire logic signed [33:0] decay_prod = mem_plus * $signed({1'b0, `MEM_DECAY});
	wire db_t decayed = db_t'(decay_prod[31:16]) - `MEM_TARGET_DB;

	// First stage vector, from codebook or from memory under loss
	generate
		for (genvar k = 0; k < 4; k++) begin : g_stage1
			assign next_g1[k] = bfi ? decayed + MEAN_GAIN :
				db_t'(cb_vector_in[16*k +: 16]) + MEAN_GAIN;
		end
	endgenerate

	// Memory reload from the average of the four gains
	wire logic signed [17:0] g1_sum = 18'(next_g1[0]) + 18'(next_g1[1]) +
		18'(next_g1[2]) + 18'(next_g1[3]);
	wire db_t next_mem = db_t'(g1_sum >>> 2) - MEAN_GAIN;

	// Subframe count per frame length: 4 << shift
	wire logic [1:0] sub_shift = (flen == full_length_frame) ? 2'd2 :
		(flen == half_length_frame) ? 2'd1 : 2'd0;
	wire logic [2:0] log2_nb = 3'(sub_shift) + 3'd2;
	wire logic last_sub = (5'(sub) + 5'd1) == (5'd4 << sub_shift);

	// Interpolated estimate; nb is a power of two so a shift divides
	wire logic signed [16:0] match_diff = 17'(new_match) - 17'(old_match);
	wire logic signed [22:0] match_step = match_diff * $signed({1'b0, sub, 1'b0}) >>> 1;
	wire logic signed [17:0] est = 18'(old_match) + 18'(match_step >>> log2_nb);

	// Each first stage gain spans 1, 2 or 4 subframes
	wire db_t g1_sel = g1[2'(sub >> sub_shift)];

	// Second stage scalar refinement
	wire logic [1:0] idx_half = idx2[{sub, 1'b0} +: 2];
	wire logic [2:0] idx_full = idx2[6'(sub) * 6'd3 +: 3];
	wire logic signed [17:0] g2_half = $signed(18'(idx_half) * `STEP_DB) - `HALF_OFFSET_DB;
	wire logic signed [17:0] g2_full = $signed(18'(idx_full) * `STEP_DB) - `FULL_OFFSET_DB;
	wire logic signed [17:0] g2 = (bfi || flen == quarter_length_frame) ? 18'sh00000 :
		(flen == half_length_frame) ? g2_half : g2_full;

	// Decoded dB gain and its linear form
	wire logic signed [17:0] total_db = est + 18'(g1_sel) + g2;
	assign gain_s.data = db_to_lin(total_db);
	assign gain_s.valid = (gstate == gain_sub);
	assign frame_ready_out = (gstate == gain_idle);

	// Frame sequencer: latch, fetch codebook, emit subframes
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			gstate <= gain_idle;
			flen <= quarter_length_frame;
			bfi <= 1'b0;
			idx2 <= 48'h000000000000;
			new_match <= 16'sh0000;
			old_match <= 16'sh0000;
			gain_mem <= 16'sh0000;
			cb_index_out <= 7'h00;
			sub <= 4'h0;
			for (int k = 0; k < 4; k++) begin
				g1[k] <= 16'sh0000;
			end
		end else begin
			unique case (gstate)
				gain_idle: begin
					if (frame_valid_in) begin
						flen <= frame_len_in;
						bfi <= loss_vec_in[0];
						idx2 <= stage2_index_in;
						new_match <= match_gain_in;
						cb_index_out <= stage1_index_in;
						gstate <= gain_fetch;
					end
				end
				gain_fetch: begin
					g1 <= next_g1;
					gain_mem <= next_mem;
					sub <= 4'h0;
					gstate <= gain_sub;
				end
				gain_sub: begin
					if (gain_s.ready) begin
						sub <= sub + 4'h1;
						if (last_sub) begin
							old_match <= new_match;
							gstate <= gain_idle;
						end
					end
				end
				default: gstate <= gain_idle;
			endcase
		end
	end

	// ----------------------------------------
	// Pulse limiter
	// ----------------------------------------
	logic [25:0] thres; // Envelope, 8 fraction bits
	wire logic [15:0] exc_mag = exc_in[15] ? 16'(-exc_in) : exc_in;
	wire logic [25:0] mag_q = {2'b00, exc_mag, 8'h00};
	wire logic [42:0] thr_mix = 43'(thres) * 43'(`THR_FEEDBACK) + 43'(mag_q) * 43'(`THR_INPUT);
	wire logic [25:0] thr_lp = thr_mix[41:16];
	wire logic [26:0] thr_twice = {thr_lp, 1'b0};
	wire logic [26:0] excess = ({1'b0, mag_q} > thr_twice) ? {1'b0, mag_q} - thr_twice :
		27'h0000000;
	wire logic [15:0] delta = excess[23:8];
	assign exc_ready_out = exc_s.ready;
	assign exc_s.valid = exc_valid_in;
	assign exc_s.data = exc_in[15] ? exc_in + delta : exc_in - delta;

	// Envelope update on each accepted sample
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			thres <= 26'h0000000;
		end else if (exc_valid_in && exc_s.ready) begin
			thres <= thr_lp + excess[26:1];
		end
	end

	// ----------------------------------------
	// Energy smoothing
	// ----------------------------------------
	smooth_state_e sstate;
	logic signed [15:0] sample_mem [64];
	logic [5:0] cnt;
	logic [39:0] energy;
	logic [39:0] thr_t;
	logic [40:0] rem;
	logic [15:0] ratio;
	logic [15:0] root;

	// Energy of one sample; the floor stands in for 0.0001, below one LSB here
	wire logic signed [31:0] sq = syn_in * syn_in;
	wire logic [39:0] energy_acc = energy + 40'(unsigned'(sq));
	wire logic [48:0] e_up = energy * `SQRT2_UP;
	wire logic [48:0] e_down = energy * `SQRT2_DOWN;
	wire logic [39:0] t_up = e_up[47:8];
	wire logic [39:0] t_down = e_down[47:8];
	wire logic [39:0] next_t = (energy < thr_t) ? ((t_up < thr_t) ? t_up : thr_t) :
		((t_down > thr_t) ? t_down : thr_t);

	// Division and square root steps, one bit per cycle
	wire logic rem_fits = rem >= {1'b0, energy};
	wire logic [40:0] rem_less = rem - {1'b0, energy};
	wire logic [15:0] cand = root | (16'h8000 >> cnt[3:0]);
	wire logic [31:0] cand_sq = cand * cand;
	wire logic signed [32:0] scaled = sample_mem[cnt] * $signed({1'b0, root});
	wire logic signed [17:0] scaled_q = scaled[32:15];
	assign syn_s.data = (scaled_q > 18'(`SAMPLE_MAX)) ? `SAMPLE_MAX :
		(scaled_q < 18'(`SAMPLE_MIN)) ? `SAMPLE_MIN : scaled_q[15:0];
	assign syn_s.valid = (sstate == smooth_emit);
	assign syn_ready_out = (sstate == smooth_fill);

	// Whole subframe is stored because the scale depends on all 64 samples
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sstate <= smooth_fill;
			cnt <= 6'h00;
			energy <= 40'h0000000000;
			thr_t <= 40'h0000000000;
			rem <= 41'h00000000000;
			ratio <= 16'h0000;
			root <= 16'h0000;
		end else begin
			unique case (sstate)
				smooth_fill: begin
					if (syn_valid_in) begin
						sample_mem[cnt] <= syn_in;
						cnt <= cnt + 6'h01;
						energy <= energy_acc;
						if (cnt == `LAST_SAMPLE) begin
							energy <= energy_acc + `ENERGY_FLOOR;
							sstate <= smooth_thres;
						end
					end
				end
				smooth_thres: begin
					thr_t <= next_t;
					rem <= {1'b0, next_t};
					ratio <= 16'h0000;
					sstate <= smooth_div;
				end
				smooth_div: begin
					rem <= rem_fits ? {rem_less[39:0], 1'b0} : {rem[39:0], 1'b0};
					ratio <= {ratio[14:0], rem_fits};
					cnt <= cnt + 6'h01;
					if (cnt == `LAST_STEP) begin
						cnt <= 6'h00;
						root <= 16'h0000;
						sstate <= smooth_sqrt;
					end
				end
				smooth_sqrt: begin
					if (cand_sq <= {1'b0, ratio, 15'h0000}) begin
						root <= cand;
					end
					cnt <= cnt + 6'h01;
					if (cnt == `LAST_STEP) begin
						cnt <= 6'h00;
						sstate <= smooth_emit;
					end
				end
				smooth_emit: begin
					if (syn_s.ready) begin
						cnt <= cnt + 6'h01;
						if (cnt == `LAST_SAMPLE) begin
							energy <= 40'h0000000000;
							sstate <= smooth_fill;
						end
					end
				end
				default: sstate <= smooth_fill;
			endcase
		end
	end
endmodule

// [hf_codebook_model.sv]
// Behavioural gain codebook ROM standing beside the decoder.
// Assumes the decoder holds its address steady for the whole frame.
`timescale 1ns/1ps
module hf_codebook_model (
	// Address from the decoder
	input wire logic [6:0] index_in,
	// Four Q8.8 dB gains, entry k at [16k+15:16k]
	output logic [63:0] vector_out
);
	// Entry k is index times k dB; a flat lookup is enough since the address stands
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			vector_out[16*k +: 16] = {1'b0, 7'(index_in * k), 8'h00};
		end
	end
endmodule

// [hf_gain_decode_smoothing_properties.sv]
// Port checker for the high-band gain decoder and smoother.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module hf_gain_checker (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Frame and codebook
	input wire logic frame_valid_in,
	input wire logic frame_ready_out,
	input wire logic [6:0] stage1_index_in,
	input wire logic [6:0] cb_index_out,
	// Gain, excitation and synthesis streams
	input wire logic gain_valid_out,
	input wire logic gain_ready_in,
	input wire logic [31:0] gain_out,
	input wire logic exc_valid_in,
	input wire logic exc_ready_out,
	input wire logic exc_valid_out,
	input wire logic exc_ready_in,
	input wire logic [15:0] exc_out,
	input wire logic syn_valid_in,
	input wire logic syn_ready_out,
	input wire logic syn_valid_out,
	input wire logic syn_ready_in,
	input wire logic [15:0] syn_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// Accepted synthesis samples, wrapping once per 64-sample subframe
	logic [5:0] syn_taken;
	wire frame_take = frame_valid_in && frame_ready_out;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			syn_taken <= 6'h00;
		end else if (syn_valid_in && syn_ready_out) begin
			syn_taken <= syn_taken + 6'h01;
		end
	end
	reset_idle_a: assert property ($fell(rst_in) |-> frame_ready_out && !gain_valid_out
		&& !exc_valid_out && !syn_valid_out && cb_index_out == 7'h00)
		else $error("outputs not idle after reset");
	frame_busy_a: assert property (frame_take |=> !frame_ready_out [*3])
		else $error("frame taken while busy");
	cb_addr_a: assert property (frame_take |=> cb_index_out == $past(stage1_index_in))
		else $error("codebook address wrong");
	gain_first_a: assert property (frame_take |-> ##[2:60] gain_valid_out)
		else $error("no gain word after frame");
	gain_hold_a: assert property (gain_valid_out && !gain_ready_in |=> gain_valid_out
		&& $stable(gain_out)) else $error("gain word lost in stall");
	exc_answer_a: assert property (exc_valid_in && exc_ready_out |=> exc_valid_out)
		else $error("excitation not answered");
	exc_hold_a: assert property (exc_valid_out && !exc_ready_in |=> exc_valid_out
		&& $stable(exc_out)) else $error("excitation lost in stall");
	syn_hold_a: assert property (syn_valid_out && !syn_ready_in |=> syn_valid_out
		&& $stable(syn_out)) else $error("synthesis lost in stall");
	syn_count_a: assert property ($fell(syn_ready_out) |-> syn_taken == 6'h00
		##1 !syn_ready_out [*8]) else $error("subframe not 64 samples");
	frame_c: cover property (frame_take);
	gain_stall_c: cover property (gain_valid_out && !gain_ready_in);
	syn_done_c: cover property ($fell(syn_ready_out));
endmodule
bind hf_gain_decode_smoothing hf_gain_checker chk (.clk_in(clk_in), .rst_in(rst_in),
	.frame_valid_in(frame_valid_in), .frame_ready_out(frame_ready_out),
	.stage1_index_in(stage1_index_in), .cb_index_out(cb_index_out),
	.gain_valid_out(gain_valid_out), .gain_ready_in(gain_ready_in), .gain_out(gain_out),
	.exc_valid_in(exc_valid_in), .exc_ready_out(exc_ready_out), .exc_valid_out(exc_valid_out),
	.exc_ready_in(exc_ready_in), .exc_out(exc_out), .syn_valid_in(syn_valid_in),
	.syn_ready_out(syn_ready_out), .syn_valid_out(syn_valid_out),
	.syn_ready_in(syn_ready_in), .syn_out(syn_out));

// [hf_gain_decode_smoothing_tb.sv]
// Self-checking bench for the high-band gain decoder and smoother.
// Assumes the codebook model and the checker are compiled alongside.
`timescale 1ns/1ps
`include "hf_gain_defines.svh"
module hf_gain_decode_smoothing_tb;
	import hf_gain_pkg::*;
	logic clk_in, rst_in, frame_valid_in, gain_ready_in, exc_valid_in, exc_ready_in;
	logic syn_valid_in, syn_ready_in, frame_ready_out, gain_valid_out, exc_ready_out;
	logic exc_valid_out, syn_ready_out, syn_valid_out;
	frame_len_e frame_len_in;
	logic [3:0] loss_vec_in;
	logic [6:0] stage1_index_in, cb_index_out;
	logic [47:0] stage2_index_in;
	logic signed [15:0] match_gain_in, exc_in, syn_in;
	logic [63:0] cb_vector_in;
	logic [31:0] gain_out;
	logic [15:0] exc_out, syn_out;
	logic [31:0] gw [0:15];
	logic signed [15:0] ew [0:3];
	logic signed [15:0] sw [0:63];
	int gcnt, ecnt, scnt, bad_count, checked;
	hf_codebook_model rom (.index_in(cb_index_out), .vector_out(cb_vector_in));
	hf_gain_decode_smoothing uut (.clk_in(clk_in), .rst_in(rst_in),
		.frame_valid_in(frame_valid_in), .frame_ready_out(frame_ready_out),
		.frame_len_in(frame_len_in), .loss_vec_in(loss_vec_in),
		.stage1_index_in(stage1_index_in), .stage2_index_in(stage2_index_in),
		.match_gain_in(match_gain_in), .cb_index_out(cb_index_out),
		.cb_vector_in(cb_vector_in), .gain_valid_out(gain_valid_out),
		.gain_ready_in(gain_ready_in), .gain_out(gain_out), .exc_valid_in(exc_valid_in),
		.exc_ready_out(exc_ready_out), .exc_in(exc_in), .exc_valid_out(exc_valid_out),
		.exc_ready_in(exc_ready_in), .exc_out(exc_out), .syn_valid_in(syn_valid_in),
		.syn_ready_out(syn_ready_out), .syn_in(syn_in), .syn_valid_out(syn_valid_out),
		.syn_ready_in(syn_ready_in), .syn_out(syn_out));
	// ----------------------------------------
	// Clock and output collectors
	// ----------------------------------------
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// Every handshaken word is kept, so a lost or doubled word shows in the counts
	always @(posedge clk_in) begin
		if (gain_valid_out === 1'b1 && gain_ready_in === 1'b1) begin
			gw[gcnt[3:0]] <= gain_out;
			gcnt <= gcnt + 1;
		end
		if (exc_valid_out === 1'b1 && exc_ready_in === 1'b1) begin
			ew[ecnt[1:0]] <= exc_out;
			ecnt <= ecnt + 1;
		end
		if (syn_valid_out === 1'b1 && syn_ready_in === 1'b1) begin
			sw[scnt[5:0]] <= syn_out;
			scnt <= scnt + 1;
		end
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic close_out();
		$display("mismatches %0d comparisons %0d", bad_count, checked);
		if (bad_count == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic check_eq(string what, logic [31:0] exp, logic [31:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	// Range compare: the linear and root stages are approximate by design;
	// the linear mantissa reads up to about 6 % above the exact gain, never far below
	task automatic check_in(string what, int lo, int hi, logic signed [31:0] got);
		checked++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			bad_count++;
			$display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask
	task automatic timed_out(string what);
		bad_count++;
		$display("ERROR %s expected handshake seen timeout", what);
		close_out();
	endtask
	task automatic send_frame(frame_len_e len, logic loss, logic [6:0] idx, logic [47:0] s2);
		int n;
		n = 0;
		gcnt = 0;
		@(posedge clk_in);
		frame_len_in <= len;
		loss_vec_in <= !loss ? 4'h0 : len == quarter_length_frame ? 4'h1 :
			len == half_length_frame ? 4'h3 : 4'hf;
		stage1_index_in <= idx;
		stage2_index_in <= s2;
		frame_valid_in <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
		end while (frame_ready_out !== 1'b1 && n < 100);
		if (n >= 100) timed_out("frame");
		frame_valid_in <= 1'b0;
	endtask
	task automatic wait_gains(int want);
		int n;
		n = 0;
		while (gcnt < want && n < 400) begin
			@(posedge clk_in);
			n++;
		end
		if (n >= 400) timed_out("gain words");
		repeat (10) @(posedge clk_in);
		check_eq("gain word count", want, gcnt);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Two lost frames in a row: memory decays to -2 dB, then -3.8 dB
	task automatic sc_loss();
		send_frame(full_length_frame, 1'b1, 7'h05, 48'hffffffffffff);
		wait_gains(16);
		check_eq("codebook address", 32'h5, {25'h0, cb_index_out});
		for (int i = 0; i < 16; i++) check_in("lost full gain", 51500, 55500, gw[i]);
		send_frame(quarter_length_frame, 1'b1, 7'h00, 48'h0);
		wait_gains(4);
		for (int i = 0; i < 4; i++) check_in("lost quarter gain", 41800, 45100, gw[i]);
	endtask
	// Codebook 0,2,4,6 dB behind a receiver stall; stage two must be ignored
	task automatic sc_quarter();
		gain_ready_in <= 1'b0;
		send_frame(quarter_length_frame, 1'b0, 7'h02, 48'hffffffffffff);
		repeat (12) @(posedge clk_in);
		check_eq("stalled words", 0, gcnt);
		gain_ready_in <= 1'b1;
		wait_gains(4);
		check_eq("0 dB gain", `LIN_ONE, gw[0]);
		check_in("2 dB gain", 81600, 87900, gw[1]);
		check_in("4 dB gain", 102800, 110700, gw[2]);
		check_in("6 dB gain", 129400, 139300, gw[3]);
	endtask
	task automatic sc_half();
		send_frame(half_length_frame, 1'b0, 7'h00, 48'h3333);
		wait_gains(8);
		check_in("plus 4.5 dB gain", 108900, 117200, gw[0]);
		check_in("minus 4.5 dB gain", 38600, 41600, gw[1]);
	endtask
	task automatic sc_full();
		send_frame(full_length_frame, 1'b0, 7'h00, 48'he00000000000);
		wait_gains(16);
		for (int i = 0; i < 15; i++) check_in("minus 10.5 dB gain", 19300, 20900, gw[i]);
		check_in("plus 10.5 dB gain", 217300, 233800, gw[15]);
	endtask
	// Matching gain steps from 0 to 8 dB: estimate ramps 0,2,4,6 dB, then holds 8 dB
	task automatic sc_match();
		match_gain_in <= 16'sh0800;
		send_frame(quarter_length_frame, 1'b0, 7'h00, 48'h0);
		wait_gains(4);
		check_eq("ramp start gain", `LIN_ONE, gw[0]);
		check_in("ramp 4 dB gain", 102800, 110700, gw[2]);
		check_in("ramp 6 dB gain", 129400, 139300, gw[3]);
		send_frame(quarter_length_frame, 1'b0, 7'h00, 48'h0);
		wait_gains(4);
		for (int i = 0; i < 4; i++) check_in("held 8 dB gain", 162900, 175400, gw[i]);
	endtask
	// Envelope from zero: partial limit, pass, clip positive, clip negative
	task automatic sc_exc();
		int n;
		int vin [0:3] = '{1000, -1000, 5000, -20000};
		int lo [0:3] = '{36, -1000, 1195, -5706};
		int hi [0:3] = '{44, -1000, 1204, -5694};
		ecnt = 0;
		@(posedge clk_in);
		for (int i = 0; i < 4; i++) begin
			exc_in <= 16'(vin[i]);
			exc_ready_in <= (i != 2); // One-cycle receiver stall on the third sample
			exc_valid_in <= 1'b1;
			n = 0;
			do begin
				@(posedge clk_in);
				n++;
			end while (exc_ready_out !== 1'b1 && n < 50);
			if (n >= 50) timed_out("excitation");
		end
		exc_valid_in <= 1'b0;
		repeat (5) @(posedge clk_in);
		check_eq("excitation count", 4, ecnt);
		for (int i = 0; i < 4; i++) check_in("limited sample", lo[i], hi[i], ew[i]);
	endtask
	// Rising, rising again then falling energy; the first subframe waits on a stall
	task automatic sc_syn();
		int n;
		int vals [0:2] = '{1000, 2000, 100};
		int lo [0:2] = '{837, 1677, 116};
		int hi [0:2] = '{842, 1683, 120};
		for (int s = 0; s < 3; s++) begin
			scnt = 0;
			@(posedge clk_in);
			syn_ready_in <= (s != 0);
			for (int i = 0; i < 64; i++) begin
				syn_in <= 16'(vals[s]);
				syn_valid_in <= 1'b1;
				n = 0;
				do begin
					@(posedge clk_in);
					n++;
				end while (syn_ready_out !== 1'b1 && n < 200);
				if (n >= 200) timed_out("synthesis");
			end
			syn_valid_in <= 1'b0;
			repeat (60) @(posedge clk_in);
			syn_ready_in <= 1'b1;
			n = 0;
			while (scnt < 64 && n < 200) begin
				@(posedge clk_in);
				n++;
			end
			repeat (4) @(posedge clk_in);
			check_eq("subframe samples", 64, scnt);
			for (int i = 0; i < 64; i++) check_in("smoothed", lo[s], hi[s], sw[i]);
		end
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst_in = 1'b1;
		frame_valid_in = 1'b0;
		frame_len_in = quarter_length_frame;
		loss_vec_in = 4'h0;
		stage1_index_in = 7'h00;
		stage2_index_in = 48'h0;
		match_gain_in = 16'sh0000;
		gain_ready_in = 1'b1;
		exc_valid_in = 1'b0;
		exc_in = 16'sh0000;
		exc_ready_in = 1'b1;
		syn_valid_in = 1'b0;
		syn_in = 16'sh0000;
		syn_ready_in = 1'b1;
		gcnt = 0;
		ecnt = 0;
		scnt = 0;
		bad_count = 0;
		checked = 0;
		repeat (12) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		check_eq("idle after reset", 32'h70, {25'h0, frame_ready_out, exc_ready_out,
			syn_ready_out, gain_valid_out, exc_valid_out, syn_valid_out, |cb_index_out});
		sc_exc();
		sc_loss();
		sc_quarter();
		sc_half();
		sc_full();
		sc_match();
		sc_syn();
		close_out();
	end
endmodule
